// >>> inc/fpp_defines.svh
// address indices, reset values and field positions of the four-pin port
// assumes an AHB-Lite word bus: byte address is four times the index
`ifndef FPP_DEFINES_SVH
`define FPP_DEFINES_SVH

`define FPP_IDX_DATA     16'hFFD7
`define FPP_IDX_DIR      16'hFFE7
`define FPP_IDX_CFG      16'hFFF7
`define FPP_ADDR_DATA    ({14'h0000, `FPP_IDX_DATA, 2'b00})
`define FPP_ADDR_DIR     ({14'h0000, `FPP_IDX_DIR, 2'b00})
`define FPP_ADDR_CFG     ({14'h0000, `FPP_IDX_CFG, 2'b00})

`define FPP_RST_DATA     8'hF8
`define FPP_RST_DIR      8'hF8
`define FPP_DIR_READ     8'hFF
`define FPP_UPPER_ONES   4'hF
`define FPP_REG_MSB      7
`define FPP_UPPER_LSB    4
`define FPP_RST_CFG      10'h000
`define FPP_CFG_W        10
`define FPP_GPIO_W       3
`define FPP_PIN_IN       3
`define FPP_RX_PIN       1
`define FPP_TX_PIN       2
`define FPP_CLK_PIN      0
`define FPP_HTRANS_NSEQ  2'h2
`define FPP_HRESP_OKAY   1'b0
`define FPP_WORD_ZERO    32'h0000_0000

`endif

// >>> inc/fpp_pkg.sv
// types shared by the four-pin port and its bench
// assumes fpp_defines.svh is on the include path
`default_nettype none
`include "fpp_defines.svh"

package fpp_pkg;

  typedef enum logic [2:0] {
    FPP_ACTIVE,
    FPP_SUBACTIVE,
    FPP_SLEEP,
    FPP_SUBSLEEP,
    FPP_WATCH,
    FPP_STANDBY
  } fpp_opmode_t;

  // layout of the serial/mode control word, bit 0 last
  typedef struct packed {
    fpp_opmode_t opMode;
    logic        interruptZeroSelect;
    logic        serialTwoCommMode;
    logic        clockSelectLow;
    logic        clockSelectHigh;
    logic        receiveEnable;
    logic        transmitEnable;
    logic        serialTwoPortSelect;
  } fpp_cfg_t;

  typedef struct packed {
    logic [`FPP_GPIO_W-1:0] out;
    logic [`FPP_GPIO_W-1:0] oe;
  } fpp_pin_drv_t;

endpackage

`default_nettype wire

// >>> rtl/fpp_port.sv
// four-pin port: three two-way pins, one input-only pin, serial/irq mux
// assumes one AHB-Lite master, synchronous pin inputs, one 100 MHz clock
//
// Operation
// RULE1: three two-way pins, pin three input only
// RULE2: data read: stored if output, pin if input
// RULE3: direction one drives stored data, zero inputs
// RULE4: data and direction reset to F8
// RULE5: direction register write-only, reads all ones
// RULE6: gpio settings apply only to unclaimed pins
// RULE7: pin three feeds interrupt when selected
// RULE8: pin two transmits when select and enable
// RULE9: pin one receives while receive enabled
// RULE10: pin zero serial clock in or out
// RULE11: high-z in reset/standby, hold in sleeps
// RULE12: upper bits ignore writes, read as ones
`default_nettype none
`include "fpp_defines.svh"

module fpp_port (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output var  logic                 hreadyout,
  output var  logic                 hresp,
  output var  logic [31:0]          hrdata,
  input  wire logic [3:0]           pinIn,
  output var  fpp_pkg::fpp_pin_drv_t pinDrive,
  input  wire logic                 serialTwoTxOut,
  input  wire logic                 serialTwoClockOut,
  output var  logic                 serialTwoRxIn,
  output var  logic                 serialTwoClockIn,
  output var  logic                 interruptZeroLevel
);

  logic [`FPP_GPIO_W-1:0] dataReg;
  logic [`FPP_GPIO_W-1:0] dataNext;
  logic [`FPP_GPIO_W-1:0] dirReg;
  logic [`FPP_GPIO_W-1:0] dirNext;
  fpp_pkg::fpp_cfg_t      cfgReg;
  fpp_pkg::fpp_cfg_t      cfgNext;
  logic                   wrPendReg;
  logic [31:0]            wrAddrReg;
  logic                   addrPhase;
  logic [31:0]            rdNext;
  logic [`FPP_GPIO_W-1:0] oeWant;
  logic [`FPP_GPIO_W-1:0] outWant;
  logic                   pinsFloat;
  logic                   pinsHold;

  // only NONSEQ is used by the master; SEQ would be treated alike
  assign addrPhase = hsel && hready && htrans[1];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPendReg <= 1'b0;
      wrAddrReg <= `FPP_WORD_ZERO;
    end else begin
      wrPendReg <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddrReg <= haddr;
      end
    end
  end

  // next values feed both the flops and the read mux, so a read right
  // behind a write to the same word sees the new value
  always_comb begin
    dataNext = dataReg;
    dirNext  = dirReg;
    cfgNext  = cfgReg;
    if (wrPendReg) begin
      if (wrAddrReg == `FPP_ADDR_DATA) begin
        dataNext = hwdata[`FPP_GPIO_W-1:0]; // [RULE1] [RULE12]
      end
      if (wrAddrReg == `FPP_ADDR_DIR) begin
        dirNext = hwdata[`FPP_GPIO_W-1:0]; // [RULE12]
      end
      if (wrAddrReg == `FPP_ADDR_CFG) begin
        cfgNext = fpp_pkg::fpp_cfg_t'(hwdata[`FPP_CFG_W-1:0]);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dataReg <= `FPP_GPIO_W'(`FPP_RST_DATA); // [RULE4]
      dirReg  <= `FPP_GPIO_W'(`FPP_RST_DIR);  // [RULE4]
    end else begin
      dataReg <= dataNext;
      dirReg  <= dirNext;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfgReg <= fpp_pkg::fpp_cfg_t'(`FPP_RST_CFG);
    end else begin
      cfgReg <= cfgNext;
    end
  end

  always_comb begin
    rdNext = `FPP_WORD_ZERO;
    if (haddr == `FPP_ADDR_DATA) begin
      rdNext[`FPP_REG_MSB:`FPP_UPPER_LSB] = `FPP_UPPER_ONES; // [RULE12]
      rdNext[`FPP_PIN_IN] = pinIn[`FPP_PIN_IN]; // [RULE1]
      rdNext[`FPP_GPIO_W-1:0] = (dirNext & dataNext)
                              | (~dirNext & pinIn[`FPP_GPIO_W-1:0]); // [RULE2]
    end else if (haddr == `FPP_ADDR_DIR) begin
      rdNext[`FPP_REG_MSB:0] = `FPP_DIR_READ; // [RULE5]
    end else if (haddr == `FPP_ADDR_CFG) begin
      rdNext[`FPP_CFG_W-1:0] = cfgNext;
    end
  end

  // zero wait states; unmapped words read zero and ignore writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata    <= `FPP_WORD_ZERO;
      hreadyout <= 1'b1;
      hresp     <= `FPP_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= `FPP_HRESP_OKAY;
      if (addrPhase && !hwrite) begin
        hrdata <= rdNext;
      end
    end
  end

  // pin mux: serial claims override direction and data
  always_comb begin
    oeWant  = dirReg;  // [RULE3]
    outWant = dataReg; // [RULE3]
    if (cfgReg.serialTwoPortSelect && cfgReg.transmitEnable) begin
      oeWant[`FPP_TX_PIN]  = 1'b1; // [RULE8] [RULE6]
      outWant[`FPP_TX_PIN] = serialTwoTxOut;
    end
    if (cfgReg.receiveEnable) begin
      oeWant[`FPP_RX_PIN] = 1'b0; // [RULE9] [RULE6]
    end
    if (cfgReg.clockSelectHigh) begin
      oeWant[`FPP_CLK_PIN] = 1'b0; // [RULE10]
    end else if (cfgReg.clockSelectLow || cfgReg.serialTwoCommMode) begin
      oeWant[`FPP_CLK_PIN]  = 1'b1; // [RULE10]
      outWant[`FPP_CLK_PIN] = serialTwoClockOut;
    end
  end

  // codes above standby are not defined and behave as active
  assign pinsFloat = cfgReg.opMode == fpp_pkg::FPP_STANDBY;
  assign pinsHold  = cfgReg.opMode == fpp_pkg::FPP_SLEEP
                  || cfgReg.opMode == fpp_pkg::FPP_SUBSLEEP
                  || cfgReg.opMode == fpp_pkg::FPP_WATCH;

  // drivers are off during reset, so pins float until software asks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinDrive <= '0; // [RULE11]
    end else if (pinsFloat) begin
      pinDrive.oe <= '0; // [RULE11]
    end else if (!pinsHold) begin
      pinDrive.oe  <= oeWant;
      pinDrive.out <= outWant;
    end
  end

  // idle levels are high: both serial inputs and the interrupt idle high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serialTwoRxIn      <= 1'b1;
      serialTwoClockIn   <= 1'b1;
      interruptZeroLevel <= 1'b1;
    end else begin
      serialTwoRxIn <= cfgReg.receiveEnable ? pinIn[`FPP_RX_PIN] : 1'b1; // [RULE9]
      serialTwoClockIn <= cfgReg.clockSelectHigh ? pinIn[`FPP_CLK_PIN] : 1'b1; // [RULE10]
      interruptZeroLevel <= cfgReg.interruptZeroSelect
                          ? pinIn[`FPP_PIN_IN] : 1'b1; // [RULE7]
    end
  end

  sequence s_rdDir;
    hsel && hready && htrans == `FPP_HTRANS_NSEQ && !hwrite && haddr == `FPP_ADDR_DIR;
  endsequence

  sequence s_rdData;
    hsel && hready && htrans == `FPP_HTRANS_NSEQ && !hwrite && haddr == `FPP_ADDR_DATA;
  endsequence

  sequence s_wrDataWord;
    (hsel && hready && htrans == `FPP_HTRANS_NSEQ && hwrite && haddr == `FPP_ADDR_DATA)
      ##1 1'b1;
  endsequence

  sequence s_running;
    cfgReg.opMode == fpp_pkg::FPP_ACTIVE || cfgReg.opMode == fpp_pkg::FPP_SUBACTIVE;
  endsequence

  property p_dirReadsOnes;
    @(posedge clk) disable iff (!resetn)
      s_rdDir |=> hrdata == 32'h0000_00FF;
  endproperty
  a_dirReadsOnes: assert property (p_dirReadsOnes) // [RULE5]
    else $error("direction read did not return all ones");

  property p_dataReadMix;
    @(posedge clk) disable iff (!resetn)
      s_rdData |=> hrdata[2:0] == (($past(dirNext) & $past(dataNext))
                 | (~$past(dirNext) & $past(pinIn[2:0])))
                 && hrdata[3] == $past(pinIn[3]);
  endproperty
  a_dataReadMix: assert property (p_dataReadMix) // [RULE2]
    else $error("data read mixes stored and live bits wrongly");

  property p_upperOnes;
    @(posedge clk) disable iff (!resetn)
      s_rdData |=> hrdata[7:4] == 4'hF && hrdata[31:8] == 24'h00_0000;
  endproperty
  a_upperOnes: assert property (p_upperOnes) // [RULE12]
    else $error("upper data bits not read as ones");

  property p_writeLands;
    @(posedge clk) disable iff (!resetn)
      s_wrDataWord |=> dataReg == $past(hwdata[2:0]);
  endproperty
  a_writeLands: assert property (p_writeLands) // [RULE1]
    else $error("data write not stored");

  property p_standbyFloats;
    @(posedge clk) disable iff (!resetn)
      cfgReg.opMode == fpp_pkg::FPP_STANDBY |=> pinDrive.oe == 3'h0;
  endproperty
  a_standbyFloats: assert property (p_standbyFloats) // [RULE11]
    else $error("pins driven in standby");

  property p_sleepHolds;
    @(posedge clk) disable iff (!resetn)
      (cfgReg.opMode == fpp_pkg::FPP_SLEEP)[*2] |=> $stable(pinDrive);
  endproperty
  a_sleepHolds: assert property (p_sleepHolds) // [RULE11]
    else $error("pins changed during sleep");

  property p_txClaim;
    @(posedge clk) disable iff (!resetn)
      s_running and (cfgReg.serialTwoPortSelect && cfgReg.transmitEnable)
        |=> pinDrive.oe[2] && pinDrive.out[2] == $past(serialTwoTxOut);
  endproperty
  a_txClaim: assert property (p_txClaim) // [RULE8]
    else $error("transmit pin not driven by serial output");

  property p_rxClaim;
    @(posedge clk) disable iff (!resetn)
      s_running and cfgReg.receiveEnable
        |=> !pinDrive.oe[1] && serialTwoRxIn == $past(pinIn[1]);
  endproperty
  a_rxClaim: assert property (p_rxClaim) // [RULE9]
    else $error("receive pin not an input to the serial channel");

  property p_gpioDir;
    @(posedge clk) disable iff (!resetn)
      s_running and !cfgReg.receiveEnable
        |=> pinDrive.oe[1] == $past(dirReg[1]) && pinDrive.out[1] == $past(dataReg[1]);
  endproperty
  a_gpioDir: assert property (p_gpioDir) // [RULE3] [RULE6]
    else $error("general pin ignores direction or data");

  property p_clkPin;
    @(posedge clk) disable iff (!resetn)
      s_running |=> pinDrive.oe[0] == ($past(cfgReg.clockSelectHigh) ? 1'b0
        : ($past(cfgReg.clockSelectLow) || $past(cfgReg.serialTwoCommMode))
          ? 1'b1 : $past(dirReg[0]));
  endproperty
  a_clkPin: assert property (p_clkPin) // [RULE10]
    else $error("clock pin direction wrong");

  property p_irqSelect;
    @(posedge clk) disable iff (!resetn)
      !cfgReg.interruptZeroSelect |=> interruptZeroLevel;
  endproperty
  a_irqSelect: assert property (p_irqSelect) // [RULE7]
    else $error("interrupt level active while pin three is general input");

  // first edge out of reset still shows the reset image
  property p_resetLoads;
    @(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> dataReg == `FPP_GPIO_W'(`FPP_RST_DATA)
        && dirReg == `FPP_GPIO_W'(`FPP_RST_DIR) && pinDrive.oe == 3'h0;
  endproperty
  a_resetLoads: assert property (p_resetLoads) // [RULE4]
    else $error("registers or drivers wrong after reset");

  sequence s_wrDirWord;
    (hsel && hready && htrans == `FPP_HTRANS_NSEQ && hwrite && haddr == `FPP_ADDR_DIR)
      ##1 1'b1;
  endsequence

  property p_dirWriteLands;
    @(posedge clk) disable iff (!resetn)
      s_wrDirWord |=> dirReg == $past(hwdata[`FPP_GPIO_W-1:0]);
  endproperty
  a_dirWriteLands: assert property (p_dirWriteLands) // [RULE3]
    else $error("direction write not stored");

  property p_irqFollows;
    @(posedge clk) disable iff (!resetn)
      cfgReg.interruptZeroSelect |=> interruptZeroLevel == $past(pinIn[`FPP_PIN_IN]);
  endproperty
  a_irqFollows: assert property (p_irqFollows) // [RULE7]
    else $error("interrupt level does not follow pin three");

  property p_clkInFollows;
    @(posedge clk) disable iff (!resetn)
      cfgReg.clockSelectHigh |=> serialTwoClockIn == $past(pinIn[`FPP_CLK_PIN]);
  endproperty
  a_clkInFollows: assert property (p_clkInFollows) // [RULE10]
    else $error("serial clock input does not follow pin zero");

  property p_clkInIdle;
    @(posedge clk) disable iff (!resetn)
      !cfgReg.clockSelectHigh |=> serialTwoClockIn;
  endproperty
  a_clkInIdle: assert property (p_clkInIdle) // [RULE10]
    else $error("serial clock input not idle while pin zero unclaimed");

  property p_rxIdle;
    @(posedge clk) disable iff (!resetn)
      !cfgReg.receiveEnable |=> serialTwoRxIn;
  endproperty
  a_rxIdle: assert property (p_rxIdle) // [RULE9]
    else $error("receive input not idle while receive disabled");

  property p_clkOut;
    @(posedge clk) disable iff (!resetn)
      s_running and (!cfgReg.clockSelectHigh
        && (cfgReg.clockSelectLow || cfgReg.serialTwoCommMode))
        |=> pinDrive.out[`FPP_CLK_PIN] == $past(serialTwoClockOut);
  endproperty
  a_clkOut: assert property (p_clkOut) // [RULE10]
    else $error("clock pin does not carry the serial clock");

  // pin two falls back to general use unless both claim bits are set
  property p_txPinGpio;
    @(posedge clk) disable iff (!resetn)
      s_running and !(cfgReg.serialTwoPortSelect && cfgReg.transmitEnable)
        |=> pinDrive.oe[`FPP_TX_PIN] == $past(dirReg[`FPP_TX_PIN])
          && pinDrive.out[`FPP_TX_PIN] == $past(dataReg[`FPP_TX_PIN]);
  endproperty
  a_txPinGpio: assert property (p_txPinGpio) // [RULE6]
    else $error("unclaimed pin two ignores direction or data");

endmodule

`default_nettype wire

// >>> test/fpp_board.sv
// board side of the four port pins: resolves each wire
// assumes the port's oe/out pair and the bench's own pin levels
`default_nettype none

module fpp_board (
  input  wire logic [3:0]            ext,
  input  wire fpp_pkg::fpp_pin_drv_t drv,
  output var  logic [3:0]            pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin three is never driven by the port
  // a driven pin shows the port's level, else the board's
  assign pinIn = {ext[3], (drv.oe & drv.out) | (~drv.oe & ext[2:0])};
endmodule

`default_nettype wire

// >>> test/fpp_port_tb.sv
// bench for the four-pin port: bus tasks, pin board, queued checks
// assumes fpp_board beside it and the include path set
`default_nettype none
`include "fpp_defines.svh"

module fpp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk, resetn, hsel, hwrite, hready, hresp;
  logic [1:0]            htrans;
  logic [31:0]           haddr, hwdata, hrdata, resV, r;
  logic [3:0]            ext, pinIn;
  logic                  tx, ck, rxIn, ckIn, irq;
  logic [2:0]            dr, dt;
  fpp_pkg::fpp_pin_drv_t drv;
  logic [31:0]           expQ[$];
  event                  resEv;
  int                    err_total, n_checks, i;
  localparam logic [9:0] CFG_T [9] = '{10'h000, 10'h003, 10'h001, 10'h004,
    10'h008, 10'h010, 10'h020, 10'h040, 10'h018};
  localparam logic [8:0] EXP_T [9] = '{9'h1C7, 9'h1E7, 9'h1C7, 9'h0C5,
    9'h146, 9'h1CF, 9'h1CF, 9'h187, 9'h146};

  fpp_port dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .pinIn(pinIn), .pinDrive(drv), .serialTwoTxOut(tx),
    .serialTwoClockOut(ck), .serialTwoRxIn(rxIn),
    .serialTwoClockIn(ckIn), .interruptZeroLevel(irq));
  fpp_board board (.ext(ext), .drv(drv), .pinIn(pinIn));

  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= `FPP_HTRANS_NSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task cmp(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // the delay keeps two notes in one step from losing an event
  task note(input logic [31:0] g, e);
    expQ.push_back(e);
    resV = g;
    ->resEv;
    #1;
  endtask

  task wr(input logic [31:0] a, d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [31:0] a, e);
    bus(1'b0, a, 32'h0000_0000);
    note(r, e);
    note({31'h0000_0000, hresp}, {31'h0000_0000, `FPP_HRESP_OKAY});
  endtask

  // pin outputs land one flop after the register
  task pins(input logic [8:0] e);
    repeat (3) @(posedge clk);
    #2;
    note({23'h00_0000, rxIn, ckIn, irq, drv.out & drv.oe, drv.oe},
      {23'h00_0000, e});
  endtask

  function automatic logic [31:0] dexp();
    return {24'h00_0000, 4'hF, ext[3], (dr & dt) | (~dr & ext[2:0])};
  endfunction

  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    forever begin
      @(resEv);
      cmp(resV, expQ.pop_front());
    end
  end

  initial begin
    #200000;
    err_total++;
    complete_run();
  end

  initial begin
    {resetn, hsel, hwrite, htrans, tx, ck} = '0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    ext = 4'h0;
    err_total = 0;
    n_checks = 0;
    void'($urandom(32'hcef8));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    ext <= 4'($urandom());
    dr = 3'h0;
    dt = 3'h0;
    pins(9'h1C0);
    rd(`FPP_ADDR_DIR, 32'h0000_00FF);
    rd(`FPP_ADDR_DATA, dexp());
    rd(32'h0000_0100, 32'h0000_0000);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      dr = 3'($urandom());
      dt = 3'($urandom());
      ext <= 4'($urandom());
      wr(`FPP_ADDR_DIR, {29'h1FFF_FFFF, dr});
      wr(`FPP_ADDR_DATA, {29'h1FFF_FFFF, dt});
      pins({3'h7, dt & dr, dr});
      rd(`FPP_ADDR_DATA, dexp());
      rd(`FPP_ADDR_DIR, 32'h0000_00FF);
    end
    $display("test gpio done");
    wr(`FPP_ADDR_DIR, 32'h0000_0007);
    wr(`FPP_ADDR_DATA, 32'h0000_0000);
    tx <= 1'b1;
    ck <= 1'b1;
    ext <= 4'h0;
    for (i = 0; i < 9; i++) begin
      wr(`FPP_ADDR_CFG, {22'h00_0000, CFG_T[i]});
      pins(EXP_T[i]);
    end
    $display("test serial mux done");
    wr(`FPP_ADDR_CFG, 32'h0000_0000);
    wr(`FPP_ADDR_DATA, 32'h0000_0005);
    for (i = 2; i < 5; i++) begin
      wr(`FPP_ADDR_CFG, {22'h00_0000, 3'(i), 7'h00});
      wr(`FPP_ADDR_DATA, 32'h0000_0002);
      pins(9'h1EF);
    end
    wr(`FPP_ADDR_CFG, 32'h0000_0280);
    pins(9'h1C0);
    wr(`FPP_ADDR_CFG, 32'h0000_0080);
    pins(9'h1D7);
    $display("test modes done");
    complete_run();
  end
endmodule

`default_nettype wire
